// >>> hw/alu_if.sv
// carrier between the execution core and its flag-producing alu
// assumes 8-bit operands
interface alu_if;
    logic [7:0]             a;
    logic [7:0]             b;
    mcu_ctl_pkg::alu_op_t   op;
    logic [7:0]             res;
    logic                   c;
    logic                   dcy;
    logic                   z;
    modport calc (input a, b, op, output res, c, dcy, z);
    modport user (output a, b, op, input res, c, dcy, z);
endinterface

// >>> hw/flag_alu.sv
// 8-bit and/add unit with carry, digit carry and zero
// assumes the core latches the flags it wants
module flag_alu (
    alu_if.calc u
);
    logic [8:0] sum;
    logic [4:0] lo;

    always_comb begin
        sum = {1'b0, u.a} + {1'b0, u.b};
        lo  = {1'b0, u.a[3:0]} + {1'b0, u.b[3:0]};
        if (u.op == mcu_ctl_pkg::ALU_ADD) begin
            u.res = sum[7:0];
        end else begin
            u.res = u.a & u.b;
        end
        u.c  = sum[8];
        u.dcy = lo[4];
        u.z  = (u.res == 8'h00);
    end
endmodule // flag_alu

// >>> hw/mcu_ctl_core.sv
// control, inherent, indirect and and/add execution core
// assumes one instruction offered per cycle, i_instr held until taken
//
// Overview of operation
// - pc-changing ops take two cycles, second idle
// - indirect access, effective address msb set: one extra cycle
// - relative branch by 9-bit literal or w
// - call and jump absolute, call via w
// - returns take two cycles, one loads w
// - standby and watchdog clear set timeout flag, standby clears power-down
// - w copied into option register
// - w copied into selected pin direction register
// - pointer add signed 6-bit literal, flags kept
// - pointer arithmetic wraps modulo 16 bits
// - indirect load with inc/dec, sets zero
// - indirect store with inc/dec, flags kept
// - indexed indirect load, sets zero
// - indexed indirect store, flags kept
// - literal and into w, zero only
// - literal add into w, carry, digit carry and zero flags
// - register and with 7-bit address, zero only
// - destination bit picks w or file register
module mcu_ctl_core #(
    parameter int unsigned DMEM_DEPTH  = 256,
    parameter int unsigned STACK_DEPTH = 16
) (
    // clock and reset
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_reset_n,
    // instruction fetch
    input  wire logic                          i_instr_valid,
    input  wire logic [13:0]                   i_instr,
    output logic                               o_instr_ready,
    output logic [14:0]                        o_pc,
    // core status
    output logic                               o_sleep,
    output logic                               o_wdt_clear,
    output logic                               o_soft_reset,
    output logic [7:0]                         o_option,
    // axi4-lite write
    input  wire logic                          i_awvalid,
    input  wire logic [mcu_ctl_pkg::AXI_AW-1:0] i_awaddr,
    output logic                               o_awready,
    input  wire logic                          i_wvalid,
    input  wire logic [31:0]                   i_wdata,
    input  wire logic [3:0]                    i_wstrb,
    output logic                               o_wready,
    output logic                               o_bvalid,
    output logic [1:0]                         o_bresp,
    input  wire logic                          i_bready,
    // axi4-lite read
    input  wire logic                          i_arvalid,
    input  wire logic [mcu_ctl_pkg::AXI_AW-1:0] i_araddr,
    output logic                               o_arready,
    output logic                               o_rvalid,
    output logic [31:0]                        o_rdata,
    output logic [1:0]                         o_rresp,
    input  wire logic                          i_rready
);
    localparam int unsigned MW = $clog2(DMEM_DEPTH);
    localparam int unsigned SW = $clog2(STACK_DEPTH);

    typedef enum logic [1:0] {ST_RUN, ST_NOP2, ST_STALL} state_t;

    ////////////////////////////////////////////////////////////////////////
    // core state
    state_t      state_q, state_d;
    logic [14:0] pc_q, pc_d;
    logic [7:0]  w_q, w_d;
    logic [4:0]  stat_q, stat_d;
    logic [15:0] fsr_q [2];
    logic [15:0] fsr_d [2];
    logic [7:0]  opt_q, opt_d;
    logic [7:0]  pdir_q [8];
    logic [7:0]  pdir_d [8];
    logic [7:0]  wdat;
    logic [SW-1:0] sp_q, sp_d;
    logic        ready_q, ready_d;
    logic        sleep_q, sleep_d;
    logic        wdt_q, wdt_d;
    logic        srst_q, srst_d;

    logic [7:0]  mem_q [DMEM_DEPTH];
    logic [14:0] stk_q [STACK_DEPTH];
    logic        mem_we;
    logic [15:0] ea;
    logic [7:0]  rd;
    logic        push;
    logic [14:0] push_val;

    logic        run_q, run_d;
    logic        wake_q, wake_d;

    logic [13:0] ins;
    logic        take;
    logic        two;
    logic        extra;
    logic        n;
    logic [15:0] ptr;
    logic [15:0] step;
    logic [15:0] k6;

    alu_if alu ();

    flag_alu u_alu (
        .u (alu.calc)
    );

    assign ins  = i_instr;
    assign take = i_instr_valid & ready_q;
    assign rd   = mem_q[ea[MW-1:0]];
    assign k6   = {{10{ins[5]}}, ins[5:0]};

    ////////////////////////////////////////////////////////////////////////
    // decode and execute
    always_comb begin
        state_d  = state_q;
        pc_d     = pc_q;
        w_d      = w_q;
        stat_d   = stat_q;
        fsr_d    = fsr_q;
        opt_d    = opt_q;
        pdir_d   = pdir_q;
        wdat     = w_q;
        sp_d     = sp_q;
        sleep_d  = sleep_q & ~wake_q;
        wdt_d    = 1'b0;
        srst_d   = 1'b0;
        mem_we   = 1'b0;
        ea       = 16'h0000;
        push     = 1'b0;
        push_val = pc_q + 15'd1;
        two      = 1'b0;
        extra    = 1'b0;
        n        = 1'b0;
        ptr      = fsr_q[0];
        step     = 16'h0001;
        alu.a    = w_q;
        alu.b    = ins[7:0];
        alu.op   = mcu_ctl_pkg::ALU_AND;
        case (state_q)
            ST_NOP2: begin
                state_d = ST_RUN;
            end
            ST_STALL: begin
                state_d = ST_RUN;
            end
            ST_RUN: begin
                if (take) begin
                    pc_d = pc_q + 15'd1;
                    if (ins[13:9] == mcu_ctl_pkg::PFX_REL) begin
                        pc_d = pc_q + 15'd1 + {{6{ins[8]}}, ins[8:0]};
                        two  = 1'b1;
                    end else if (ins == mcu_ctl_pkg::OP_BR_W) begin
                        pc_d = pc_q + 15'd1 + {7'h00, w_q};
                        two  = 1'b1;
                    end else if (ins[13:11] == mcu_ctl_pkg::PFX_CALL) begin
                        push = 1'b1;
                        sp_d = sp_q + 1'b1;
                        pc_d = {4'h0, ins[10:0]};
                        two  = 1'b1;
                    end else if (ins == mcu_ctl_pkg::OP_CALL_W) begin
                        push = 1'b1;
                        sp_d = sp_q + 1'b1;
                        pc_d = {7'h00, w_q};
                        two  = 1'b1;
                    end else if (ins[13:11] == mcu_ctl_pkg::PFX_JUMP) begin
                        pc_d = {4'h0, ins[10:0]};
                        two  = 1'b1;
                    end else if (ins == mcu_ctl_pkg::OP_RETURN ||
                                 ins == mcu_ctl_pkg::OP_RETINT) begin
                        sp_d = sp_q - 1'b1;
                        pc_d = stk_q[sp_d];
                        two  = 1'b1;
                    end else if (ins[13:8] == mcu_ctl_pkg::PFX_RETK) begin
                        w_d  = ins[7:0];
                        sp_d = sp_q - 1'b1;
                        pc_d = stk_q[sp_d];
                        two  = 1'b1;
                    end else if (ins == mcu_ctl_pkg::OP_WDTCLR) begin
                        stat_d[mcu_ctl_pkg::ST_TMO] = 1'b1;
                        stat_d[mcu_ctl_pkg::ST_PDN] = 1'b1;
                        wdt_d = 1'b1;
                    end else if (ins == mcu_ctl_pkg::OP_SLEEP) begin
                        stat_d[mcu_ctl_pkg::ST_TMO] = 1'b1;
                        stat_d[mcu_ctl_pkg::ST_PDN] = 1'b0;
                        wdt_d   = 1'b1;
                        sleep_d = 1'b1;
                    end else if (ins == mcu_ctl_pkg::OP_OPTION) begin
                        opt_d = w_q;
                    end else if (ins[13:3] == mcu_ctl_pkg::PFX_PDIR) begin
                        pdir_d[ins[2:0]] = w_q;
                    end else if (ins == mcu_ctl_pkg::OP_RESET) begin
                        srst_d = 1'b1;
                    end else if (ins[13:7] == mcu_ctl_pkg::PFX_PTRADD) begin
                        n = ins[6];
                        fsr_d[n] = fsr_q[n] + k6;
                    end else if (ins[13:3] == mcu_ctl_pkg::PFX_LDI ||
                                 ins[13:3] == mcu_ctl_pkg::PFX_STI) begin
                        n    = ins[2];
                        step = ins[0] ? 16'hFFFF : 16'h0001;
                        ptr  = fsr_q[n] + step;
                        fsr_d[n] = ptr;
                        ea   = ins[1] ? fsr_q[n] : ptr;
                        extra = ea[15];
                        if (ins[3]) begin
                            mem_we = 1'b1;
                        end else begin
                            w_d = rd;
                            stat_d[mcu_ctl_pkg::ST_Z] = (rd == 8'h00);
                        end
                    end else if (ins[13:7] == mcu_ctl_pkg::PFX_LDX ||
                                 ins[13:7] == mcu_ctl_pkg::PFX_STX) begin
                        n     = ins[6];
                        ea    = fsr_q[n] + k6;
                        extra = ea[15];
                        if (ins[7]) begin
                            mem_we = 1'b1;
                        end else begin
                            w_d = rd;
                            stat_d[mcu_ctl_pkg::ST_Z] = (rd == 8'h00);
                        end
                    end else if (ins[13:8] == mcu_ctl_pkg::PFX_ANDK) begin
                        w_d = alu.res;
                        stat_d[mcu_ctl_pkg::ST_Z] = alu.z;
                    end else if (ins[13:8] == mcu_ctl_pkg::PFX_ADDK) begin
                        alu.op = mcu_ctl_pkg::ALU_ADD;
                        w_d = alu.res;
                        stat_d[mcu_ctl_pkg::ST_C]   = alu.c;
                        stat_d[mcu_ctl_pkg::ST_DCY] = alu.dcy;
                        stat_d[mcu_ctl_pkg::ST_Z]   = alu.z;
                    end else if (ins[13:8] == mcu_ctl_pkg::PFX_ANDF) begin
                        if (ins[6:0] == mcu_ctl_pkg::F_INDIRECT0 ||
                            ins[6:0] == mcu_ctl_pkg::F_INDIRECT1) begin
                            ea    = fsr_q[ins[0]];
                            extra = ea[15];
                        end else begin
                            ea = {9'h000, ins[6:0]};
                        end
                        alu.b = rd;
                        stat_d[mcu_ctl_pkg::ST_Z] = alu.z;
                        if (ins[7]) begin
                            mem_we = 1'b1;
                            wdat   = alu.res;
                        end else begin
                            w_d = alu.res;
                        end
                    end
                    if (two) begin
                        state_d = ST_NOP2;
                    end else if (extra) begin
                        state_d = ST_STALL;
                    end
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
        ready_d = (state_d == ST_RUN) & run_q & ~sleep_d & ~srst_d;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n || srst_q) begin
            state_q <= ST_RUN;
            pc_q    <= mcu_ctl_pkg::PC_RST;
            w_q     <= 8'h00;
            stat_q  <= mcu_ctl_pkg::STATUS_RST;
            fsr_q   <= '{default: 16'h0000};
            opt_q   <= mcu_ctl_pkg::OPTION_RST;
            pdir_q  <= '{default: mcu_ctl_pkg::PDIR_RST};
            sp_q    <= '0;
            ready_q <= 1'b0;
            sleep_q <= 1'b0;
            wdt_q   <= 1'b0;
            srst_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            w_q     <= w_d;
            stat_q  <= stat_d;
            fsr_q   <= fsr_d;
            opt_q   <= opt_d;
            pdir_q  <= pdir_d;
            sp_q    <= sp_d;
            ready_q <= ready_d;
            sleep_q <= sleep_d;
            wdt_q   <= wdt_d;
            srst_q  <= srst_d;
        end
    end

    // data memory and return stack hold no reset
    always_ff @(posedge i_ref_clk) begin
        if (mem_we) begin
            mem_q[ea[MW-1:0]] <= wdat;
        end
        if (push) begin
            stk_q[sp_q] <= push_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    logic        awv_q, awv_d, wv_q, wv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d;
    logic        wst_q, wst_d;
    logic        awr_q, awr_d, wr_q, wr_d;
    logic        bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic [31:0] rdat_q, rdat_d;

    always_comb begin
        awv_d  = awv_q;
        awa_d  = awa_q;
        wv_d   = wv_q;
        wd_d   = wd_q;
        wst_d  = wst_q;
        bv_d   = bv_q & ~i_bready;
        br_d   = br_q;
        run_d  = run_q;
        wake_d = 1'b0;
        rv_d   = rv_q & ~i_rready;
        rr_d   = rr_q;
        rdat_d = rdat_q;
        if (i_awvalid && awr_q) begin
            awv_d = 1'b1;
            awa_d = i_awaddr;
        end
        if (i_wvalid && wr_q) begin
            wv_d  = 1'b1;
            wd_d  = i_wdata;
            wst_d = i_wstrb[0];
        end
        if (awv_q && wv_q && !bv_q) begin
            bv_d  = 1'b1;
            awv_d = 1'b0;
            wv_d  = 1'b0;
            br_d  = mcu_ctl_pkg::RESP_SLVERR;
            if (awa_q == mcu_ctl_pkg::OFF_CTRL) begin
                br_d = mcu_ctl_pkg::RESP_OKAY;
                if (wst_q) begin
                    run_d  = wd_q[mcu_ctl_pkg::CTRL_RUN];
                    wake_d = wd_q[mcu_ctl_pkg::CTRL_WAKE];
                end
            end
        end
        if (i_arvalid && arr_q) begin
            rv_d   = 1'b1;
            rr_d   = mcu_ctl_pkg::RESP_OKAY;
            rdat_d = 32'h0000_0000;
            if (i_araddr[7:5] == mcu_ctl_pkg::OFF_PDIR_HI) begin
                rdat_d[7:0] = pdir_q[i_araddr[4:2]];
            end else begin
                case ({i_araddr[7:2], 2'b00})
                    mcu_ctl_pkg::OFF_CTRL:   rdat_d[0]    = run_q;
                    mcu_ctl_pkg::OFF_W:      rdat_d[7:0]  = w_q;
                    mcu_ctl_pkg::OFF_STATUS: rdat_d[4:0]  = stat_q;
                    mcu_ctl_pkg::OFF_PTR0:   rdat_d[15:0] = fsr_q[0];
                    mcu_ctl_pkg::OFF_PTR1:   rdat_d[15:0] = fsr_q[1];
                    mcu_ctl_pkg::OFF_OPTION: rdat_d[7:0]  = opt_q;
                    mcu_ctl_pkg::OFF_PC:     rdat_d[14:0] = pc_q;
                    default:                 rr_d = mcu_ctl_pkg::RESP_SLVERR;
                endcase
            end
        end
        awr_d = ~awv_d;
        wr_d  = ~wv_d;
        arr_d = ~rv_d;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            awv_q  <= 1'b0;
            awa_q  <= 8'h00;
            wv_q   <= 1'b0;
            wd_q   <= 32'h0000_0000;
            wst_q  <= 1'b0;
            awr_q  <= 1'b0;
            wr_q   <= 1'b0;
            bv_q   <= 1'b0;
            br_q   <= 2'h0;
            arr_q  <= 1'b0;
            rv_q   <= 1'b0;
            rr_q   <= 2'h0;
            rdat_q <= 32'h0000_0000;
            run_q  <= mcu_ctl_pkg::CTRL_RUN_RST;
            wake_q <= 1'b0;
        end else begin
            awv_q  <= awv_d;
            awa_q  <= awa_d;
            wv_q   <= wv_d;
            wd_q   <= wd_d;
            wst_q  <= wst_d;
            awr_q  <= awr_d;
            wr_q   <= wr_d;
            bv_q   <= bv_d;
            br_q   <= br_d;
            arr_q  <= arr_d;
            rv_q   <= rv_d;
            rr_q   <= rr_d;
            rdat_q <= rdat_d;
            run_q  <= run_d;
            wake_q <= wake_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_instr_ready = ready_q;
    assign o_pc          = pc_q;
    assign o_sleep       = sleep_q;
    assign o_wdt_clear   = wdt_q;
    assign o_soft_reset  = srst_q;
    assign o_option      = opt_q;
    assign o_awready     = awr_q;
    assign o_wready      = wr_q;
    assign o_bvalid      = bv_q;
    assign o_bresp       = br_q;
    assign o_arready     = arr_q;
    assign o_rvalid      = rv_q;
    assign o_rdata       = rdat_q;
    assign o_rresp       = rr_q;

endmodule // mcu_ctl_core

// >>> hw/mcu_ctl_pkg.sv
// constants shared by the control/indirect execution core
// assumes 14-bit instruction words and 8-bit data
package mcu_ctl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // fixed encodings
    localparam logic [13:0] OP_NOP    = 14'h0000;
    localparam logic [13:0] OP_RESET  = 14'h0001;
    localparam logic [13:0] OP_RETURN = 14'h0008;
    localparam logic [13:0] OP_RETINT = 14'h0009;
    localparam logic [13:0] OP_CALL_W = 14'h000A;
    localparam logic [13:0] OP_BR_W   = 14'h000B;
    localparam logic [13:0] OP_OPTION = 14'h0062;
    localparam logic [13:0] OP_SLEEP  = 14'h0063;
    localparam logic [13:0] OP_WDTCLR = 14'h0064;

    // opcode prefixes, compared against the top bits of the word
    localparam logic [4:0]  PFX_REL    = 5'h19;  // [13:9]
    localparam logic [2:0]  PFX_CALL   = 3'h4;   // [13:11]
    localparam logic [2:0]  PFX_JUMP   = 3'h5;   // [13:11]
    localparam logic [5:0]  PFX_RETK   = 6'h34;  // [13:8]
    localparam logic [5:0]  PFX_ANDK   = 6'h39;  // [13:8]
    localparam logic [5:0]  PFX_ADDK   = 6'h3E;  // [13:8]
    localparam logic [5:0]  PFX_ANDF   = 6'h05;  // [13:8]
    localparam logic [6:0]  PFX_PTRADD = 7'h62;  // [13:7]
    localparam logic [6:0]  PFX_LDX    = 7'h7E;  // [13:7]
    localparam logic [6:0]  PFX_STX    = 7'h7F;  // [13:7]
    localparam logic [10:0] PFX_PDIR   = 11'h00C; // [13:3]
    localparam logic [10:0] PFX_LDI    = 11'h002; // [13:3]
    localparam logic [10:0] PFX_STI    = 11'h003; // [13:3]

    // file addresses of the two indirect access registers
    localparam logic [6:0]  F_INDIRECT0 = 7'h00;
    localparam logic [6:0]  F_INDIRECT1 = 7'h01;

    ////////////////////////////////////////////////////////////////////////
    // status bit positions and reset value
    localparam int unsigned ST_C   = 0;
    localparam int unsigned ST_DCY = 1;
    localparam int unsigned ST_Z   = 2;
    localparam int unsigned ST_PDN = 3;
    localparam int unsigned ST_TMO = 4;
    localparam logic [4:0]  STATUS_RST = 5'h18;
    localparam logic [7:0]  OPTION_RST = 8'hFF;
    localparam logic [7:0]  PDIR_RST   = 8'hFF;
    localparam logic [14:0] PC_RST     = 15'h0000;

    ////////////////////////////////////////////////////////////////////////
    // register bus map (byte addresses)
    localparam int unsigned AXI_AW     = 8;
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_W      = 8'h04;
    localparam logic [7:0]  OFF_STATUS = 8'h08;
    localparam logic [7:0]  OFF_PTR0   = 8'h0C;
    localparam logic [7:0]  OFF_PTR1   = 8'h10;
    localparam logic [7:0]  OFF_OPTION = 8'h14;
    localparam logic [7:0]  OFF_PC     = 8'h18;
    localparam logic [2:0]  OFF_PDIR_HI = 3'h1;  // 0x20..0x3C, [7:5]
    localparam int unsigned CTRL_RUN  = 0;
    localparam int unsigned CTRL_WAKE = 1;
    localparam logic        CTRL_RUN_RST = 1'b1;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic {ALU_AND, ALU_ADD} alu_op_t;

endpackage

// >>> verif/mcu_ctl_sva.sv
// checker on instruction timing, targets and the read channel
// assumes bind into mcu_ctl_core, sync active-low reset
module mcu_ctl_sva (
    // observed ports
    input wire logic        i_ref_clk, i_reset_n, i_instr_valid, o_instr_ready,
    input wire logic        o_sleep, o_wdt_clear, i_arvalid, o_arready, o_rvalid,
    input wire logic [13:0] i_instr,
    input wire logic [14:0] o_pc
);
    wire        tk = i_instr_valid & o_instr_ready;
    wire [13:0] w  = i_instr;
    wire [10:0] ak = i_instr[10:0];
    wire        wk = tk && (w == 14'h0063 || w == 14'h0064);
    wire [14:0] bt = o_pc + 15'h0001 + {{6{w[8]}}, w[8:0]};
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    ////////////////////////////////////////////////////////////////////////
    rel_stall_a: assert property (
        tk && w[13:9] == 5'h19 |=> !o_instr_ready ##1 o_instr_ready) else $error("branch stall");
    rel_target_a: assert property (
        tk && w[13:9] == 5'h19 |=> o_pc == $past(bt)) else $error("branch target");
    jump_target_a: assert property (
        tk && w[13:11] == 3'h5 |=> o_pc[10:0] == $past(ak)) else $error("jump target");
    call_stall_a: assert property (
        tk && (w[13:11] == 3'h4 || w == 14'h000A) |=> !o_instr_ready ##1 o_instr_ready)
        else $error("call stall");
    ret_stall_a: assert property (
        tk && (w[13:1] == 13'h0004 || w[13:8] == 6'h34) |=> !o_instr_ready)
        else $error("return stall");
    wdt_pulse_a: assert property (wk |=> o_wdt_clear) else $error("no wdt pulse");
    wdt_cause_a: assert property (
        o_wdt_clear |-> $past(wk)) else $error("stray wdt pulse");
    sleep_entry_a: assert property (
        tk && w == 14'h0063 |=> o_sleep && !o_instr_ready) else $error("standby entry");
    one_cycle_a: assert property (
        tk && (w[13:3] == 11'h00C && w != 14'h0063 || w[13:7] == 7'h62 || w[13:8] == 6'h39
        || w[13:8] == 6'h3E) |=> o_instr_ready) else $error("single cycle op stalled");
    read_answer_a: assert property (
        i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
endmodule // mcu_ctl_sva

bind mcu_ctl_core mcu_ctl_sva u_sva (.*);

// >>> verif/prog_mem_model.sv
// program memory model: offers one instruction word at a time
// assumes the core takes the word at a rising edge with ready high
module prog_mem_model (
    // clock and handshake
    input  wire logic   i_ref_clk,
    input  wire logic   i_instr_ready,
    // instruction word
    output logic        o_instr_valid,
    output logic [13:0] o_instr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_instr_valid = 1'b0;
        o_instr       = 14'h0000;
    end
    // released word line shows the inverse, never the last word
    task automatic issue(input logic [13:0] w);
        o_instr_valid <= 1'b1;
        o_instr       <= w;
        do @(posedge i_ref_clk); while (i_instr_ready !== 1'b1);
        o_instr_valid <= 1'b0;
        o_instr       <= ~w;
    endtask
endmodule // prog_mem_model

// >>> verif/tb.sv
// self-checking bench: words fed by the program memory model,
// results read back over the register bus; needs prog_mem_model
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = '0, rst_n = '0, iv, rdy, sl, awv = '0, awr, wv = '0, wrd;
    logic        bv, br = '0, arv = '0, arr, rv, rr = '0, srst;
    logic [13:0] ins;
    logic [7:0]  awa = '0, ara = '0, opt;
    logic [31:0] wd = '0, rdat;
    logic [1:0]  bresp, rresp;
    int          errors = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    mcu_ctl_core DUT (.i_ref_clk(clk), .i_reset_n(rst_n), .i_instr_valid(iv), .i_instr(ins),
        .o_instr_ready(rdy), .o_pc(), .o_sleep(sl), .o_wdt_clear(), .o_soft_reset(srst),
        .o_option(opt), .i_awvalid(awv), .i_awaddr(awa), .o_awready(awr), .i_wvalid(wv),
        .i_wdata(wd), .i_wstrb(4'hF), .o_wready(wrd), .o_bvalid(bv), .o_bresp(bresp),
        .i_bready(br), .i_arvalid(arv), .i_araddr(ara), .o_arready(arr), .o_rvalid(rv),
        .o_rdata(rdat), .o_rresp(rresp), .i_rready(rr));
    prog_mem_model u_pm (.i_ref_clk(clk), .i_instr_ready(rdy), .o_instr_valid(iv), .o_instr(ins));
    ////////////////////////////////////////////////////////////////////////
    // one word, then ready as seen in the cycle after it was taken
    task automatic ex(input logic [13:0] w, input logic r);
        u_pm.issue(w);
        @(posedge clk);
        `CHK("ready", r, rdy)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; br <= 1'b1;
        fork
            begin do @(posedge clk); while (!awr); awv <= 1'b0; end
            begin do @(posedge clk); while (!wrd); wv <= 1'b0; end
        join
        do @(posedge clk); while (!bv);
        br <= 1'b0;
        `CHK("bresp", e, bresp)
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        arv <= 1'b1; ara <= a; rr <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rr <= 1'b0;
        `CHK($sformatf("reg %h", a), e, rdat)
        `CHK("rresp", 2'h0, rresp)
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_lit();
        ex(14'h345A, 1'b0); rc(8'h04, 8'h5A);
        ex(14'h39A5, 1'b1); rc(8'h04, 8'h00); rc(8'h08, 8'h1C);
        ex(14'h34F0, 1'b0); ex(14'h3E1F, 1'b1); rc(8'h04, 8'h0F);
        rc(8'h08, 8'h19); ex(14'h3EF1, 1'b1); rc(8'h08, 8'h1F);
    endtask
    task automatic t_ctl();
        ex(14'h3410, 1'b0); ex(14'h2923, 1'b0); rc(8'h18, 16'h123);
        ex(14'h33FD, 1'b0); rc(8'h18, 16'h121);
        ex(14'h000B, 1'b0); rc(8'h18, 16'h132);
        ex(14'h000A, 1'b0); rc(8'h18, 16'h010);
        ex(14'h2200, 1'b0); rc(8'h18, 16'h200);
        ex(14'h0009, 1'b0); rc(8'h18, 16'h011);
        ex(14'h0008, 1'b0); rc(8'h18, 16'h133);
    endtask
    task automatic t_ind();
        ex(14'h313F, 1'b1); rc(8'h0C, 16'hFFFF); rc(8'h08, 8'h1F);
        ex(14'h001A, 1'b0); rc(8'h0C, 16'h0000);
        ex(14'h313F, 1'b1); ex(14'h3900, 1'b1); ex(14'h0013, 1'b0);
        rc(8'h04, 8'h10); rc(8'h0C, 16'hFFFE); rc(8'h08, 8'h1B);
        ex(14'h3FC3, 1'b1); ex(14'h3900, 1'b1); ex(14'h3F43, 1'b1);
        rc(8'h04, 8'h10); ex(14'h3143, 1'b1); ex(14'h3430, 1'b0);
        ex(14'h0581, 1'b1); rc(8'h04, 8'h30);
        ex(14'h3421, 1'b0); ex(14'h0501, 1'b1); rc(8'h04, 8'h00);
        rc(8'h08, 8'h1F);
    endtask
    task automatic t_inh();
        ex(14'h3455, 1'b0); ex(14'h0062, 1'b1); `CHK("option", 8'h55, opt)
        rc(8'h14, 8'h55);
        ex(14'h0065, 1'b1); rc(8'h34, 8'h55);
        ex(14'h0063, 1'b0); `CHK("standby", 1'b1, sl)
        rc(8'h08, 8'h17); wr(8'h04, 32'h0, 2'h2);
        wr(8'h00, 32'h3, 2'h0); ex(14'h0064, 1'b1); rc(8'h08, 8'h1F);
        ex(14'h0001, 1'b0); `CHK("soft reset", 1'b1, srst)
        @(posedge clk); `CHK("option", 8'hFF, opt)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_lit();
        t_ctl();
        t_ind();
        t_inh();
        end_sim();
    end
    initial begin
        repeat (4000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule // tb
